// ==== hw/boot_map_pkg.sv ====
// Package: constants and carrier types for the boot mode and overlay map block
package boot_map_pkg;
  // ----------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------
  localparam int CODE_WIDTH = 24;
  localparam int DATA_WIDTH = 16;
  localparam int HOST_BUS_WIDTH = 16;
  localparam int ADDR_WIDTH = 14;
  localparam int OVL_LOW_BITS = 13;
  localparam logic [13:0] OVL_WINDOW_LO = 14'h2000;
  localparam logic [13:0] OVL_WINDOW_HI = 14'h3FFF;
  localparam logic [13:0] INT_WORDS = 14'h3FFF;
  localparam logic [5:0] BOOT_WORDS = 6'h20;
  localparam logic [5:0] MMR_COUNT = 6'h20;
  localparam logic [13:0] MMR_BASE = 14'h3FE0;
  localparam logic [13:0] RESET_VECTOR = 14'h0000;

  // ----------------------------------------------------------------
  // Overlay selector codes and wait field
  // ----------------------------------------------------------------
  localparam logic [1:0] OVL_INTERNAL = 2'h0;
  localparam logic [1:0] OVL_EXT_ONE = 2'h1;
  localparam logic [1:0] OVL_EXT_TWO = 2'h2;
  localparam int WAIT_WIDTH = 3;
  localparam logic [3:0] WAIT_MODE_EXTRA = 4'h1;

  // ----------------------------------------------------------------
  // Strap decoding
  // ----------------------------------------------------------------
  localparam logic [2:0] STRAP_BYTE_BOOT_FULL = 3'h0;
  localparam logic [2:0] STRAP_NO_BOOT_FULL = 3'h2;
  localparam logic [2:0] STRAP_BYTE_BOOT_HOST = 3'h4;
  localparam logic [2:0] STRAP_HOST_PORT_BOOT = 3'h5;

  typedef enum logic [1:0] {BOOT_BYTE, BOOT_NONE, BOOT_HOST_PORT, BOOT_INVALID} boot_src_t;

  typedef struct packed {
    logic hostMode;
    logic ackOpenDrain;
    boot_src_t bootSrc;
  } mode_cfg_t;

  localparam mode_cfg_t MODE_RESET = '{hostMode: 1'b0, ackOpenDrain: 1'b0, bootSrc: BOOT_NONE};

  typedef struct packed {
    logic hit;
    logic external;
    logic highBit;
    logic [OVL_LOW_BITS-1:0] lowAddr;
  } ovl_map_t;
endpackage

// ==== hw/boot_mode_and_overlay_map.sv ====
// Boot strap capture, boot sequencing, overlay address mapping and wait states
//
// Implementation choices: the address map.
`timescale 1ns/100ps
module boot_mode_and_overlay_map (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic strapA,
  input wire logic strapB,
  input wire logic strapD,
  input wire logic flagTwoIn,
  output logic flagTwoOut,
  output logic flagTwoOe,
  input wire logic flagTwoDir,
  input wire logic flagTwoData,
  input wire logic byteDmaWordDone,
  input wire logic hostCodeWrite,
  input wire logic [13:0] hostCodeAddr,
  input wire logic hostAckReq,
  output logic hostAckOut,
  output logic hostAckOe,
  input wire logic [1:0] code_overlay_select,
  input wire logic [1:0] data_overlay_select,
  input wire logic codeReq,
  input wire logic codeFetch,
  input wire logic [13:0] codeAddr,
  input wire logic dataReq,
  input wire logic [13:0] dataAddr,
  input wire logic [boot_map_pkg::WAIT_WIDTH-1:0] data_wait_count,
  input wire logic waitModeSel,
  output logic hostModeOut,
  output logic ackOpenDrainOut,
  output logic [1:0] bootSrcOut,
  output logic byteDmaBootReq,
  output logic runEnable,
  output logic startExternal,
  output logic codeExtSel,
  output logic codeFetchFault,
  output logic dataExtSel,
  output logic dataMmrSel,
  output logic overlay_high_addr_bit,
  output logic [boot_map_pkg::OVL_LOW_BITS-1:0] extAddr,
  output logic dataBusy
);
  import boot_map_pkg::*;
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] strapMeta_q, strapSync_q;
  logic rstSeen_q, rstSeen_d;

  always_ff @(posedge clk) begin
    strapMeta_q <= {strapD, flagTwoIn, strapB, strapA};
    strapSync_q <= strapMeta_q;
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  mode_cfg_t cfg_q, cfg_d;

  function automatic mode_cfg_t decode_straps(input logic [3:0] s);
    mode_cfg_t m;
    m = MODE_RESET;
    case (s[2:0])
      STRAP_BYTE_BOOT_FULL: m.bootSrc = BOOT_BYTE;
      STRAP_NO_BOOT_FULL: m.bootSrc = BOOT_NONE;
      STRAP_BYTE_BOOT_HOST: begin
        m.bootSrc = BOOT_BYTE;
        m.hostMode = 1'b1;
      end
      STRAP_HOST_PORT_BOOT: begin
        m.bootSrc = BOOT_HOST_PORT;
        m.hostMode = 1'b1;
      end
      default: m.bootSrc = BOOT_INVALID;
    endcase
    // Strap d matters only in host mode
    m.ackOpenDrain = m.hostMode & s[3];
    return m;
  endfunction

  always_comb begin
    rstSeen_d = 1'b0;
    cfg_d = cfg_q;
    if (rst_b) begin
      rstSeen_d = 1'b0;
      // Capture on the first cycle after release, never again
      if (rstSeen_q) begin
        cfg_d = decode_straps(strapSync_q);
      end
    end else begin
      rstSeen_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rstSeen_q <= 1'b1;
      cfg_q <= MODE_RESET;
    end else begin
      rstSeen_q <= rstSeen_d;
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_RESET, ST_DECIDE, ST_BYTE_LOAD, ST_HOST_WAIT, ST_RUN, ST_HALT}
    boot_state_t;
  boot_state_t state_q, state_d;
  logic [5:0] bootCount_q, bootCount_d;
  logic startExt_q, startExt_d;

  always_comb begin
    state_d = state_q;
    bootCount_d = bootCount_q;
    startExt_d = startExt_q;
    case (state_q)
      ST_RESET: state_d = ST_DECIDE;
      ST_DECIDE: begin
        bootCount_d = 6'h00;
        case (cfg_q.bootSrc)
          BOOT_BYTE: state_d = ST_BYTE_LOAD;
          BOOT_HOST_PORT: state_d = ST_HOST_WAIT;
          BOOT_NONE: begin
            startExt_d = 1'b1;
            state_d = ST_RUN;
          end
          default: state_d = ST_HALT;
        endcase
      end
      ST_BYTE_LOAD: begin
        if (byteDmaWordDone) begin
          bootCount_d = bootCount_q + 6'h01;
          if (bootCount_q + 6'h01 == BOOT_WORDS) begin
            state_d = ST_RUN;
          end
        end
      end
      ST_HOST_WAIT: begin
        if (hostCodeWrite && hostCodeAddr == RESET_VECTOR) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_HALT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_RESET;
      bootCount_q <= 6'h00;
      startExt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bootCount_q <= bootCount_d;
      startExt_q <= startExt_d;
    end
  end

  assign byteDmaBootReq = (state_q == ST_BYTE_LOAD);
  // Byte DMA stays usable in the no-boot mode; the core just does not wait on it
  assign runEnable = (state_q == ST_RUN);
  assign startExternal = startExt_q;
  assign hostModeOut = cfg_q.hostMode;
  assign ackOpenDrainOut = cfg_q.ackOpenDrain;
  assign bootSrcOut = cfg_q.bootSrc;

  // ----------------------------------------------------------------
  // Flag two pin and host acknowledge pin
  // ----------------------------------------------------------------
  logic flagOut_q, flagOut_d, flagOe_q, flagOe_d;
  logic ackOut_q, ackOut_d, ackOe_q, ackOe_d;

  always_comb begin
    // Pin released while in reset so the board strap driver owns it
    flagOe_d = flagTwoDir;
    flagOut_d = flagTwoData;
    ackOe_d = 1'b0;
    ackOut_d = 1'b0;
    if (cfg_q.hostMode) begin
      if (cfg_q.ackOpenDrain) begin
        // Drive high only; the external pull-down gives the low level
        ackOut_d = 1'b1;
        ackOe_d = hostAckReq;
      end else begin
        ackOut_d = hostAckReq;
        ackOe_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flagOut_q <= 1'b0;
      flagOe_q <= 1'b0;
      ackOut_q <= 1'b0;
      ackOe_q <= 1'b0;
    end else begin
      flagOut_q <= flagOut_d;
      flagOe_q <= flagOe_d;
      ackOut_q <= ackOut_d;
      ackOe_q <= ackOe_d;
    end
  end

  assign flagTwoOut = flagOut_q;
  assign flagTwoOe = flagOe_q;
  assign hostAckOut = ackOut_q;
  assign hostAckOe = ackOe_q;

  // ----------------------------------------------------------------
  // Overlay mapping
  // ----------------------------------------------------------------
  function automatic ovl_map_t map_overlay(input logic [1:0] sel, input logic [13:0] addr,
                                           input logic host);
    ovl_map_t m;
    m = '0;
    m.hit = (addr >= OVL_WINDOW_LO) && (addr <= OVL_WINDOW_HI);
    if (m.hit && (sel == OVL_EXT_ONE || sel == OVL_EXT_TWO)) begin
      m.external = 1'b1;
      m.highBit = (sel == OVL_EXT_TWO);
      m.lowAddr = addr[OVL_LOW_BITS-1:0];
      if (host) begin
        // Only the low address line reaches the pins in host mode
        m.highBit = 1'b0;
        m.lowAddr = {{(OVL_LOW_BITS-1){1'b0}}, addr[0]};
      end
    end
    return m;
  endfunction

  ovl_map_t codeMap, dataMap;
  logic [OVL_LOW_BITS-1:0] extAddr_q, extAddr_d;
  logic highBit_q, highBit_d, codeExt_q, codeExt_d, dataExt_q, dataExt_d;
  logic fault_q, fault_d, mmr_q, mmr_d;
  logic [3:0] waitCnt_q, waitCnt_d;

  always_comb begin
    codeMap = map_overlay(code_overlay_select, codeAddr, cfg_q.hostMode);
    dataMap = map_overlay(data_overlay_select, dataAddr, cfg_q.hostMode);
    extAddr_d = extAddr_q;
    highBit_d = highBit_q;
    codeExt_d = 1'b0;
    dataExt_d = 1'b0;
    fault_d = 1'b0;
    mmr_d = dataReq && !dataMap.external && dataAddr >= MMR_BASE;
    waitCnt_d = (waitCnt_q != 4'h0) ? waitCnt_q - 4'h1 : 4'h0;
    if (waitCnt_q == 4'h0) begin
      if (dataReq && dataMap.external) begin
        dataExt_d = 1'b1;
        extAddr_d = dataMap.lowAddr;
        highBit_d = dataMap.highBit;
        // Wait mode doubles the count plus one
        waitCnt_d = waitModeSel ? {data_wait_count, 1'b0} + WAIT_MODE_EXTRA
                                : {1'b0, data_wait_count};
      end else if (codeReq && codeMap.external) begin
        if (cfg_q.hostMode && codeFetch) begin
          fault_d = 1'b1;
        end else begin
          codeExt_d = 1'b1;
          extAddr_d = codeMap.lowAddr;
          highBit_d = codeMap.highBit;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      extAddr_q <= '0;
      highBit_q <= 1'b0;
      codeExt_q <= 1'b0;
      dataExt_q <= 1'b0;
      fault_q <= 1'b0;
      mmr_q <= 1'b0;
      waitCnt_q <= 4'h0;
    end else begin
      extAddr_q <= extAddr_d;
      highBit_q <= highBit_d;
      codeExt_q <= codeExt_d;
      dataExt_q <= dataExt_d;
      fault_q <= fault_d;
      mmr_q <= mmr_d;
      waitCnt_q <= waitCnt_d;
    end
  end

  // Internal accesses never stall, host mode included
  assign dataBusy = (waitCnt_q != 4'h0);
  assign extAddr = extAddr_q;
  assign overlay_high_addr_bit = highBit_q;
  assign codeExtSel = codeExt_q;
  assign dataExtSel = dataExt_q;
  assign codeFetchFault = fault_q;
  assign dataMmrSel = mmr_q;
endmodule

// ==== tb/boot_mode_and_overlay_map_assertions.sv ====
// Checker: mapping, wait and mode properties of the block
`timescale 1ns/100ps
module boot_map_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic dataReq,
  input wire logic dataBusy,
  input wire logic [13:0] dataAddr,
  input wire logic [1:0] data_overlay_select,
  input wire logic hostModeOut,
  input wire logic dataExtSel,
  input wire logic overlay_high_addr_bit,
  input wire logic [boot_map_pkg::OVL_LOW_BITS-1:0] extAddr,
  input wire logic codeReq,
  input wire logic codeFetch,
  input wire logic [13:0] codeAddr,
  input wire logic [1:0] code_overlay_select,
  input wire logic codeFetchFault,
  input wire logic codeExtSel,
  input wire logic waitModeSel,
  input wire logic [boot_map_pkg::WAIT_WIDTH-1:0] data_wait_count,
  input wire logic ackOpenDrainOut,
  input wire logic hostAckOe,
  input wire logic hostAckOut,
  input wire logic hostAckReq,
  input wire logic [1:0] bootSrcOut,
  input wire logic runEnable,
  input wire logic byteDmaWordDone,
  input wire logic hostCodeWrite,
  input wire logic [13:0] hostCodeAddr,
  input wire logic startExternal
);
  import boot_map_pkg::*;
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  wire dTake = dataReq && !dataBusy && dataAddr[13] && (dataAddr < MMR_BASE);
  wire [12:0] dLow = dataAddr[12:0];
  wire hostZero = hostCodeWrite && (hostCodeAddr == RESET_VECTOR);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ovl_one_map: assert property (dTake && !hostModeOut && data_overlay_select == OVL_EXT_ONE
    |=> dataExtSel && !overlay_high_addr_bit && extAddr == $past(dLow))
    else $error("overlay one mapping wrong");
  a_ovl_two_map: assert property (dTake && !hostModeOut && data_overlay_select == OVL_EXT_TWO
    |=> dataExtSel && overlay_high_addr_bit && extAddr == $past(dLow))
    else $error("overlay two mapping wrong");
  a_host_low_line: assert property (dTake && hostModeOut && data_overlay_select != 2'h0
    |=> !overlay_high_addr_bit && extAddr == ($past(dLow) & 13'h0001))
    else $error("host mode address not single line");
  a_fetch_fault: assert property (hostModeOut && codeReq && codeFetch && !dataReq && !dataBusy
    && codeAddr[13] && code_overlay_select != 2'h0 |=> codeFetchFault && !codeExtSel)
    else $error("external fetch in host mode not refused");
  a_wait_three: assert property (dTake && data_overlay_select != 2'h0
    && ((!waitModeSel && data_wait_count == 3'h3) || (waitModeSel && data_wait_count == 3'h1))
    |=> dataBusy [*3] ##1 !dataBusy)
    else $error("wait state count wrong");
  a_internal_fast: assert property (dataReq && !dataBusy && data_overlay_select == 2'h0
    |=> !dataExtSel && !dataBusy)
    else $error("internal access not single cycle");
  a_push_pull: assert property (hostModeOut && !ackOpenDrainOut
    |=> hostAckOe && hostAckOut == $past(hostAckReq))
    else $error("driven acknowledge wrong");
  a_open_drain: assert property (hostModeOut && ackOpenDrainOut
    |=> hostAckOut && hostAckOe == $past(hostAckReq))
    else $error("open drain acknowledge wrong");
  a_cfg_held: assert property (rst_b [*5] |-> $stable(hostModeOut) && $stable(bootSrcOut)
    && $stable(ackOpenDrainOut))
    else $error("mode configuration changed");
  a_run_cause: assert property ($rose(runEnable)
    |-> $past(byteDmaWordDone) || $past(hostZero) || startExternal)
    else $error("run started without cause");
  c_ovl_two: cover property (dTake && data_overlay_select == OVL_EXT_TWO);
  c_run: cover property ($rose(runEnable));
  c_fault: cover property (codeFetchFault);
endmodule
bind boot_mode_and_overlay_map boot_map_checker u_boot_map_checker (.*);

// ==== tb/boot_mode_and_overlay_map_test.sv ====
// Testbench: strap modes, boot hold, acknowledge, flag and overlay accesses
`timescale 1ns/100ps
module boot_mode_and_overlay_map_test;
  import boot_map_pkg::*;
  logic clk = 1'h0;
  logic rst_b, strapA, strapB, strapC, strapD, flagTwoIn, flagTwoOut, flagTwoOe;
  logic flagTwoDir, flagTwoData, byteDmaWordDone, hostCodeWrite, hostAckReq;
  logic hostAckOut, hostAckOe, codeReq, codeFetch, dataReq, waitModeSel;
  logic hostModeOut, ackOpenDrainOut, byteDmaBootReq, runEnable, startExternal;
  logic codeExtSel, codeFetchFault, dataExtSel, dataMmrSel, overlay_high_addr_bit;
  logic dataBusy;
  logic [1:0] code_overlay_select, data_overlay_select, bootSrcOut;
  logic [13:0] hostCodeAddr, codeAddr, dataAddr;
  logic [WAIT_WIDTH-1:0] data_wait_count;
  logic [OVL_LOW_BITS-1:0] extAddr;
  logic [13:0] notes[$];
  int mismatches = 0;
  int checksDone = 0;
  boot_mode_and_overlay_map u_boot_mode_and_overlay_map (.*);
  boot_strap_board u_boot_strap_board (.rst_b(rst_b), .strapC(strapC),
    .flagTwoOut(flagTwoOut), .flagTwoOe(flagTwoOe), .flagPin(flagTwoIn));
  always #5 clk = ~clk;
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic pls(input logic h, input logic [13:0] a);
    @(posedge clk);
    byteDmaWordDone <= !h;
    hostCodeWrite <= h;
    hostCodeAddr <= a;
    @(posedge clk);
    byteDmaWordDone <= 1'h0;
    hostCodeWrite <= 1'h0;
    #1;
  endtask
  // Busy is counted from the edge that takes the request
  task automatic acc(input logic d, input logic f, input logic [1:0] s,
    input logic [13:0] a, output int n);
    @(posedge clk);
    dataReq <= d;
    codeReq <= !d;
    codeFetch <= f;
    data_overlay_select <= s;
    code_overlay_select <= s;
    dataAddr <= a;
    codeAddr <= a;
    @(posedge clk);
    dataReq <= 1'h0;
    codeReq <= 1'h0;
    #1;
    n = 0;
    while (dataBusy === 1'h1 && n < 40) begin
      n++;
      @(posedge clk);
      #1;
    end
  endtask
  // Selects are pulses, so look at them mid-cycle
  always @(negedge clk) begin
    if (dataExtSel === 1'h1 || codeExtSel === 1'h1) begin
      if (notes.size() == 0) chk(1'h1, 1'h0);
      else chk({overlay_high_addr_bit, extAddr}, notes.pop_front());
    end
  end
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    logic [3:0] modes[7];
    logic [3:0] m;
    logic [1:0] src, s;
    logic [13:0] a;
    logic [2:0] w;
    logic host, od, md;
    int n;
    {rst_b, strapA, strapB, strapC, strapD, flagTwoDir, flagTwoData} = '0;
    {byteDmaWordDone, hostCodeWrite, hostAckReq, codeReq, codeFetch, dataReq} = '0;
    {waitModeSel, code_overlay_select, data_overlay_select, data_wait_count} = '0;
    {hostCodeAddr, codeAddr, dataAddr} = '0;
    // Last strap code is unused, so the block must halt there
    modes = '{4'h8, 4'h2, 4'h4, 4'h5, 4'hC, 4'hD, 4'h3};
    void'($urandom(26));
    foreach (modes[k]) begin
      m = modes[k];
      @(posedge clk);
      rst_b <= 1'h0;
      {strapD, strapC, strapB, strapA} <= m;
      flagTwoDir <= 1'h0;
      repeat (8) @(posedge clk);
      rst_b <= 1'h1;
      repeat (5) @(posedge clk);
      #1;
      src = (m[2:0] == 3'h2) ? 2'h1 : ((m[2:0] == 3'h5) ? 2'h2 : 2'h3);
      if (m[1:0] == 2'h0) src = 2'h0;
      host = m[2] && (src != 2'h3);
      od = m[3] && host;
      chk(hostModeOut, host);
      chk(ackOpenDrainOut, od);
      chk(bootSrcOut, src);
      chk(startExternal, src == 2'h1);
      chk(byteDmaBootReq, src == 2'h0);
      chk(runEnable, src == 2'h1);
      if (src == 2'h0 || src == 2'h2) begin
        repeat ((src == 2'h0) ? 31 : 1) pls(src[1], {13'h0000, src[1]});
        chk(runEnable, 1'h0);
        pls(src[1], 14'h0000);
        @(posedge clk);
        #1;
        chk(runEnable, 1'h1);
      end
      for (int r = 0; r < 2; r++) begin
        hostAckReq <= r[0];
        flagTwoDir <= 1'h1;
        flagTwoData <= r[0];
        repeat (2) @(posedge clk);
        #1;
        chk({flagTwoOe, flagTwoOut}, {1'h1, r[0]});
        if (host) chk({hostAckOe, hostAckOut}, od ? {r[0], 1'h1} : {1'h1, r[0]});
      end
      for (int i = 0; i < 4; i++) begin
        s = (i < 2) ? 2'h2 : ((i == 2) ? 2'h1 : 2'($urandom % 3));
        a = 14'h2000 | 14'($urandom % 14'h1FE0);
        w = (i == 0) ? 3'h3 : ((i == 1) ? 3'h1 : 3'($urandom));
        md = (i == 1) ? 1'h1 : ((i == 0) ? 1'h0 : 1'($urandom));
        data_wait_count <= w;
        waitModeSel <= md;
        if (s != 2'h0) notes.push_back(host ? {13'h0000, a[0]} : {s[1], a[12:0]});
        acc(1'h1, 1'h0, s, a, n);
        chk(n, (s == 2'h0) ? 0 : (md ? 2 * w + 1 : w));
        if (s != 2'h0 && !host) begin
          notes.push_back({s[1], a[12:0]});
          acc(1'h0, 1'h0, s, a, n);
        end
      end
      acc(1'h1, 1'h0, OVL_INTERNAL, MMR_BASE | 14'($urandom % 32), n);
      chk(dataMmrSel, 1'h1);
      chk(n, 0);
      if (host) begin
        acc(1'h0, 1'h1, 2'h1, 14'h2000, n);
        chk({codeFetchFault, codeExtSel}, 2'h2);
      end
      chk(notes.size(), 0);
    end
    summarize();
  end
endmodule

// ==== tb/boot_strap_board.sv ====
// Board model: strap driver and passive pull on the shared flag-two pin
`timescale 1ns/100ps
module boot_strap_board #(
  parameter logic PULL = 1'h1
) (
  input wire logic rst_b,
  input wire logic strapC,
  input wire logic flagTwoOut,
  input wire logic flagTwoOe,
  output logic flagPin
);
  // ------------------------------------------------
  // Pin resolution
  // ------------------------------------------------
  // Driver enabled by reset only, so the flag owns the pin afterwards
  always_comb begin
    if (flagTwoOe) begin
      flagPin = flagTwoOut;
    end else if (!rst_b) begin
      flagPin = strapC;
    end else begin
      flagPin = PULL;
    end
  end
endmodule
